// [rtl/acp_pkg.sv]
// Behaviour
// (RULE1) Several enabled bus drivers resolve to low.
// (RULE2) No enabled bus driver resolves to high.
// (RULE3) Clear and preset come from data, lines one, two.
// (RULE4) Line one copies load data without cell clock.
// (RULE5) Clear and preset act low; unused held high.
// (RULE6) Six modes, frozen while the group runs.
// (RULE7) Clear low forces the register to zero.
// (RULE8) Preset by load uses data tied high.
// (RULE9) Preset via inverted clear leaves data free.
// (RULE10) Clear-preset: line one presets, line two clears.
// (RULE11) Load-clear: line one loads, line two clears.
// (RULE12) Load-preset: line two resets state, one loads.
// (RULE13) Load-preset inverts load data for inverted output.
// (RULE14) Plain load: line two has no effect.
// (RULE15) Four group lines: two clocks, two clear/preset.
// (RULE16) Clear wins over a simultaneous load.
package acp_pkg;
    localparam int CELLS = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MODE_W = 3;

    // Gray-coded along the order in which the modes are usually listed.
    typedef enum logic [2:0] {
        MODE_CLEAR_ONLY = 3'h0,
        MODE_PRESET_ONLY = 3'h1,
        MODE_CLEAR_PRESET = 3'h3,
        MODE_LOAD_CLEAR = 3'h2,
        MODE_LOAD_PRESET = 3'h6,
        MODE_LOAD_PLAIN = 3'h7
    } acp_mode_type;

    // The four control lines shared by every cell of the group.
    typedef struct packed {
        logic line_four;
        logic line_three;
        logic group_control_line_two;
        logic group_control_line_one;
    } acp_ctrl_type;

    // One register bus request, as the master drives it in a cycle.
    typedef struct packed {
        logic write;
        logic read;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } acp_req_type;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SYNC = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CLKSEL = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_DRIVE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;

    localparam int CTRL_RUN_BIT = 0;
    localparam int STAT_LEVEL_BIT = 16;
    localparam int STAT_CONTEND_BIT = 17;
    localparam int STAT_FLOAT_BIT = 18;
    localparam int STAT_RUN_BIT = 19;

    localparam logic RUN_RESET = 1'h0;
    localparam logic BUS_IDLE_LEVEL = 1'h1;
    localparam logic CELL_RESET = 1'h0;
endpackage

// [rtl/acp_cell.sv]
`timescale 1ns/1ps
module acp_cell (
    input wire logic clock,
    input wire logic sys_rst,
    input wire acp_pkg::acp_mode_type mode,
    input wire logic async_load_data_input,
    input wire logic group_control_line_one,
    input wire logic group_control_line_two,
    input wire logic clk_en,
    input wire logic d,
    output logic q
);
    import acp_pkg::*;

    logic stored;
    logic inverted;
    logic load_value;
    logic load_act;
    logic clear_act;
    logic register_clear_low;
    logic register_preset_low;
    logic next_stored;

    // Both preset-only and load-with-preset keep the bit inverted.
    assign inverted = (mode == MODE_PRESET_ONLY) || (mode == MODE_LOAD_PRESET); // see RULE9
    // Tied high for clear-preset; inverted for the inverted register.
    assign load_value = (mode == MODE_CLEAR_PRESET) ? 1'h1 : // see RULE8
        (mode == MODE_LOAD_PRESET) ? !async_load_data_input : // see RULE13
        async_load_data_input;
    assign load_act = group_control_line_one && (mode == MODE_CLEAR_PRESET ||
        mode == MODE_LOAD_CLEAR || mode == MODE_LOAD_PRESET ||
        mode == MODE_LOAD_PLAIN); // see RULE4
    // Line two clears in every mode that has it; plain load ignores it.
    assign clear_act = (group_control_line_one && (mode == MODE_CLEAR_ONLY ||
        mode == MODE_PRESET_ONLY)) || (group_control_line_two &&
        (mode == MODE_CLEAR_PRESET || mode == MODE_LOAD_CLEAR ||
        mode == MODE_LOAD_PRESET)); // see RULE10 RULE11 RULE12 RULE14
    // Only the mode, the load data and lines one and two steer the active-low controls.
    assign register_preset_low = !(load_act && load_value); // see RULE3 RULE5
    assign register_clear_low = !(clear_act || (load_act && !load_value)); // see RULE3 RULE5
    // Clear wins, then preset, then the cell clock enable.
    assign next_stored = !register_clear_low ? 1'h0 : // see RULE7 RULE16
        !register_preset_low ? 1'h1 : clk_en ? (d ^ inverted) : stored;

    // The visible bit is registered too, so q never has a glitch path.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stored <= CELL_RESET;
            q <= CELL_RESET;
        end else begin
            stored <= next_stored;
            q <= next_stored ^ inverted;
        end
    end

    property p_clear_zero;
        @(posedge clock) disable iff (sys_rst)
        !register_clear_low |=> (stored == 1'h0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("Clear did not zero."); // see RULE7

    property p_clear_wins;
        @(posedge clock) disable iff (sys_rst)
        (mode == MODE_LOAD_CLEAR) && group_control_line_one && group_control_line_two
        |=> (q == 1'h0);
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("Load beat clear."); // see RULE16

    property p_load_copy;
        @(posedge clock) disable iff (sys_rst)
        group_control_line_one && !group_control_line_two && (mode == MODE_LOAD_CLEAR ||
        mode == MODE_LOAD_PRESET || mode == MODE_LOAD_PLAIN)
        |=> (q == $past(async_load_data_input));
    endproperty
    a_load_copy: assert property (p_load_copy) else $error("Load value lost."); // see RULE4

    property p_preset_one;
        @(posedge clock) disable iff (sys_rst)
        group_control_line_one && !group_control_line_two && (mode == MODE_CLEAR_PRESET ||
        mode == MODE_PRESET_ONLY) |=> q;
    endproperty
    a_preset_one: assert property (p_preset_one) else $error("Preset gave zero."); // see RULE10

    property p_ldpre_reset;
        @(posedge clock) disable iff (sys_rst)
        (mode == MODE_LOAD_PRESET) && group_control_line_two |=> q && !stored;
    endproperty
    a_ldpre_reset: assert property (p_ldpre_reset) else $error("Preset by clear failed."); // see RULE12

    property p_plain_two;
        @(posedge clock) disable iff (sys_rst)
        (mode == MODE_LOAD_PLAIN) && !group_control_line_one && !clk_en
        |=> $stable(stored) && (q == stored);
    endproperty
    a_plain_two: assert property (p_plain_two) else $error("Line two touched plain load."); // see RULE14

    property p_unused_high;
        @(posedge clock) disable iff (sys_rst)
        (mode == MODE_CLEAR_ONLY) || (mode == MODE_PRESET_ONLY) |-> register_preset_low;
    endproperty
    a_unused_high: assert property (p_unused_high) else $error("Unused preset active."); // see RULE5
endmodule

// [rtl/acp_group.sv]
`timescale 1ns/1ps
module acp_group #(
    parameter int CELLS = acp_pkg::CELLS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire acp_pkg::acp_req_type reg_req,
    output logic [acp_pkg::DATA_W-1:0] reg_rdata,
    input wire acp_pkg::acp_ctrl_type group_ctrl,
    input wire logic [CELLS-1:0] async_load_data_input,
    output logic [CELLS-1:0] cell_q,
    output logic bus_level,
    output logic bus_contention,
    output logic bus_floating
);
    import acp_pkg::*;

    localparam int MW = MODE_W * CELLS;

    // Picks one cell's mode field out of a packed mode word.
    function automatic logic [MODE_W-1:0] field_of(
        input logic [MW-1:0] word,
        input int idx
    );
        field_of = word[idx*MODE_W +: MODE_W];
    endfunction

    // True for the six legal mode codes only.
    function automatic logic mode_ok(input logic [MODE_W-1:0] code);
        mode_ok = (code == MODE_CLEAR_ONLY) || (code == MODE_PRESET_ONLY) ||
            (code == MODE_CLEAR_PRESET) || (code == MODE_LOAD_CLEAR) ||
            (code == MODE_LOAD_PRESET) || (code == MODE_LOAD_PLAIN);
    endfunction

    logic run;
    logic [MW-1:0] mode_word;
    logic [CELLS-1:0] sync_data;
    logic [CELLS-1:0] clk_sel;
    logic [CELLS-1:0] drive_en;
    logic [MW-1:0] next_mode_word;
    logic [CELLS-1:0] cell_clk_en;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] next_rdata;
    logic any_oe;
    logic multi_oe;
    logic sel_level;
    logic next_bus_level;

    // Write decode; one strobe, one address, one register.
    wire wr_ctrl = reg_req.write && (reg_req.addr == ADDR_CTRL);
    wire wr_sync = reg_req.write && (reg_req.addr == ADDR_SYNC);
    wire wr_clksel = reg_req.write && (reg_req.addr == ADDR_CLKSEL);
    wire wr_drive = reg_req.write && (reg_req.addr == ADDR_DRIVE);
    // Modes are configuration: a running group refuses new ones.
    wire wr_mode = reg_req.write && (reg_req.addr == ADDR_MODE) && !run; // see RULE6

    // Illegal codes leave a cell's old mode in place, per field.
    for (genvar i = 0; i < CELLS; i++) begin : g_mode
        logic [MODE_W-1:0] wr_field;
        assign wr_field = field_of(reg_req.wdata[MW-1:0], i);
        assign next_mode_word[i*MODE_W +: MODE_W] =
            mode_ok(wr_field) ? wr_field : field_of(mode_word, i); // see RULE6
    end

    // Run gates the cell clocks and freezes the mode word.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run <= RUN_RESET;
        end else if (wr_ctrl) begin
            run <= reg_req.wdata[CTRL_RUN_BIT];
        end
    end

    // Reset puts every cell into clear-only mode.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_word <= '0;
        end else if (wr_mode) begin
            mode_word <= next_mode_word;
        end
    end

    // Synchronous data each cell takes on its clock enable.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync_data <= '0;
        end else if (wr_sync) begin
            sync_data <= reg_req.wdata[CELLS-1:0];
        end
    end

    // Per-cell choice between the two clock lines of the group.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clk_sel <= '0;
        end else if (wr_clksel) begin
            clk_sel <= reg_req.wdata[CELLS-1:0];
        end
    end

    // Which cells drive the emulated shared bus.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            drive_en <= '0;
        end else if (wr_drive) begin
            drive_en <= reg_req.wdata[CELLS-1:0];
        end
    end

    // Lines three and four are the clock enables of the group.
    // Clear and preset stay live while stopped; only clocking needs run.
    for (genvar i = 0; i < CELLS; i++) begin : g_cell
        assign cell_clk_en[i] = run && (clk_sel[i] ? group_ctrl.line_four :
            group_ctrl.line_three); // see RULE15
        acp_cell u_cell (
            .clock(clock),
            .sys_rst(sys_rst),
            .mode(acp_mode_type'(field_of(mode_word, i))),
            .async_load_data_input(async_load_data_input[i]),
            .group_control_line_one(group_ctrl.group_control_line_one), // see RULE15
            .group_control_line_two(group_ctrl.group_control_line_two),
            .clk_en(cell_clk_en[i]),
            .d(sync_data[i]),
            .q(cell_q[i])
        );
    end

    // The bus is a mux; contention and floating are decoded from the drive enables.
    // Clearing the lowest set bit tells one driver from several.
    assign any_oe = |drive_en;
    assign multi_oe = |(drive_en & (drive_en - CELLS'(1)));
    assign sel_level = |(drive_en & cell_q);
    assign next_bus_level = multi_oe ? 1'h0 : // see RULE1
        (!any_oe ? 1'h1 : sel_level); // see RULE2

    // Bus level and its flags are registered like all outputs.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_level <= BUS_IDLE_LEVEL;
            bus_contention <= 1'h0;
            bus_floating <= 1'h1;
        end else begin
            bus_level <= next_bus_level;
            bus_contention <= multi_oe;
            bus_floating <= !any_oe;
        end
    end

    // Status shows the cells and the bus as they stand now.
    assign status_word = DATA_W'(cell_q) |
        (DATA_W'(bus_level) << STAT_LEVEL_BIT) |
        (DATA_W'(bus_contention) << STAT_CONTEND_BIT) |
        (DATA_W'(bus_floating) << STAT_FLOAT_BIT) |
        (DATA_W'(run) << STAT_RUN_BIT);

    // Read mux; unmapped addresses and idle cycles return zero.
    assign next_rdata = !reg_req.read ? '0 :
        (reg_req.addr == ADDR_CTRL) ? (DATA_W'(run) << CTRL_RUN_BIT) :
        (reg_req.addr == ADDR_MODE) ? DATA_W'(mode_word) :
        (reg_req.addr == ADDR_SYNC) ? DATA_W'(sync_data) :
        (reg_req.addr == ADDR_CLKSEL) ? DATA_W'(clk_sel) :
        (reg_req.addr == ADDR_DRIVE) ? DATA_W'(drive_en) :
        (reg_req.addr == ADDR_STATUS) ? status_word : '0;

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    property p_bus_low;
        @(posedge clock) disable iff (sys_rst)
        multi_oe |=> (bus_level == 1'h0) && bus_contention;
    endproperty
    a_bus_low: assert property (p_bus_low) else $error("Contention not low."); // see RULE1

    property p_bus_high;
        @(posedge clock) disable iff (sys_rst)
        !any_oe |=> bus_level && bus_floating && !bus_contention;
    endproperty
    a_bus_high: assert property (p_bus_high) else $error("Idle bus not high."); // see RULE2

    property p_bus_single;
        @(posedge clock) disable iff (sys_rst)
        any_oe && !multi_oe |=> (bus_level == |($past(drive_en) & $past(cell_q)));
    endproperty
    a_bus_single: assert property (p_bus_single) else $error("Single driver lost.");

    property p_mode_frozen;
        @(posedge clock) disable iff (sys_rst)
        run |=> $stable(mode_word);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("Mode changed in run."); // see RULE6

    property p_mode_legal;
        @(posedge clock) disable iff (sys_rst)
        wr_mode && mode_ok(reg_req.wdata[MODE_W-1:0])
        |=> (mode_word[MODE_W-1:0] == $past(reg_req.wdata[MODE_W-1:0]));
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("Mode write lost."); // see RULE6

    property p_stopped_clock;
        @(posedge clock) disable iff (sys_rst)
        !run |-> (cell_clk_en == '0);
    endproperty
    a_stopped_clock: assert property (p_stopped_clock) else $error("Clock while stopped."); // see RULE15

    property p_rdata_idle;
        @(posedge clock) disable iff (sys_rst)
        !reg_req.read |=> (reg_rdata == '0);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data held over.");

    property p_status_read;
        @(posedge clock) disable iff (sys_rst)
        reg_req.read && (reg_req.addr == ADDR_STATUS)
        |=> (reg_rdata[CELLS-1:0] == $past(cell_q)) &&
            (reg_rdata[STAT_LEVEL_BIT] == $past(bus_level));
    endproperty
    a_status_read: assert property (p_status_read) else $error("Status read wrong.");
endmodule

// [sim/acp_user_logic.sv]
`timescale 1ns/1ps
// Stands in for the user logic that drives the group lines and the per-cell load data.
module acp_user_logic #(
    parameter int CELLS = acp_pkg::CELLS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire acp_pkg::acp_ctrl_type next_ctrl,
    input wire logic [CELLS-1:0] next_data,
    output acp_pkg::acp_ctrl_type group_ctrl,
    output logic [CELLS-1:0] async_load_data_input
);
    import acp_pkg::*;

    // Lines are registered so they change just after an edge, like real user flops.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            group_ctrl <= '0;
            async_load_data_input <= '0;
        end else begin
            group_ctrl <= next_ctrl;
            async_load_data_input <= next_data;
        end
    end
endmodule

// [sim/acp_group_tb_top.sv]
`timescale 1ns/1ps
module acp_group_tb_top;
    import acp_pkg::*;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    acp_req_type reg_req = '0;
    acp_ctrl_type next_ctrl = '0;
    acp_ctrl_type group_ctrl;
    logic [7:0] next_data = 8'h00;
    logic [7:0] load_data;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rd;
    logic [7:0] cell_q;
    logic bus_level;
    logic bus_contention;
    logic bus_floating;
    int errors = 0;
    int cmp_count = 0;
    logic lines_rand = 1'h0;
    logic [15:0] seed_a = 16'h9a68;
    logic [15:0] seed_b = 16'h9a68;
    logic sh_run = 1'h0;
    logic [23:0] sh_mode = '0;
    logic [7:0] sh_sync = 8'h00;
    logic [7:0] sh_clk = 8'h00;
    logic [7:0] sh_drive = 8'h00;
    logic [7:0] exp_q = 8'h00;
    logic [7:0] exp_s = 8'h00;
    logic [7:0] next_q = 8'h00;
    logic exp_lvl = 1'h1;
    logic exp_cont = 1'h0;
    logic exp_flt = 1'h1;
    logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h7, 3'h6};
    logic [7:0] addrs [8] = '{ADDR_CTRL, ADDR_MODE, ADDR_SYNC, ADDR_CLKSEL, ADDR_DRIVE,
        ADDR_STATUS, 8'h20, ADDR_MODE};
    logic [7:0] drv [5] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hff};

    acp_user_logic #(.CELLS(8)) u_acp_user_logic (.clock(clock), .sys_rst(sys_rst),
        .next_ctrl(next_ctrl), .next_data(next_data), .group_ctrl(group_ctrl),
        .async_load_data_input(load_data));
    acp_group #(.CELLS(8)) u_acp_group (.clock(clock), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .group_ctrl(group_ctrl), .async_load_data_input(load_data),
        .cell_q(cell_q), .bus_level(bus_level), .bus_contention(bus_contention),
        .bus_floating(bus_floating));

    // Free-running system clock.
    initial begin
        forever #2 clock = ~clock;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // A mode word is refused while running; an illegal field keeps its old code.
    function automatic logic [23:0] mode_merge(input logic [23:0] o, input logic [31:0] v);
        logic [23:0] r;
        r = o;
        for (int i = 0; i < 8; i++) begin
            if (!sh_run && v[3*i+:3] != 3'h4 && v[3*i+:3] != 3'h5) r[3*i+:3] = v[3*i+:3];
        end
        return r;
    endfunction

    // Preset-only and load-with-preset keep the stored bit inverted behind q.
    function automatic logic inv_of(input logic [2:0] m);
        return (m == MODE_PRESET_ONLY) || (m == MODE_LOAD_PRESET);
    endfunction

    // Next register value: clear beats preset or load, which beat the clocked path.
    function automatic logic cell_next(input logic [2:0] m, input logic l1, input logic l2,
        input logic d, input logic en, input logic sd, input logic q);
        logic clr;
        logic pre;
        logic ld;
        clr = 1'h0;
        pre = 1'h0;
        ld = 1'h0;
        case (m)
            MODE_CLEAR_ONLY: clr = l1;
            MODE_PRESET_ONLY: pre = l1;
            MODE_CLEAR_PRESET: begin clr = l2; pre = l1; end
            MODE_LOAD_CLEAR: begin clr = l2; ld = l1; end
            MODE_LOAD_PRESET: begin pre = l2; ld = l1; end
            default: ld = l1;
        endcase
        return clr ? 1'h0 : pre ? 1'h1 : ld ? d : en ? sd : q;
    endfunction

    function automatic logic [31:0] exp_reg(input logic [7:0] a);
        case (a)
            ADDR_CTRL: return {31'h0000_0000, sh_run};
            ADDR_MODE: return {8'h00, sh_mode};
            ADDR_SYNC: return {24'h00_0000, sh_sync};
            ADDR_CLKSEL: return {24'h00_0000, sh_clk};
            ADDR_DRIVE: return {24'h00_0000, sh_drive};
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic check_bit(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_req <= '{write: 1'h1, read: 1'h0, addr: a, wdata: v};
        @(posedge clock);
        reg_req <= '0;
        if (a == ADDR_CTRL) sh_run <= v[0];
        if (a == ADDR_MODE) sh_mode <= mode_merge(sh_mode, v);
        if (a == ADDR_SYNC) sh_sync <= v[7:0];
        if (a == ADDR_CLKSEL) sh_clk <= v[7:0];
        if (a == ADDR_DRIVE) sh_drive <= v[7:0];
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_req <= '{write: 1'h0, read: 1'h1, addr: a, wdata: 32'h0000_0000};
        @(posedge clock);
        reg_req <= '0;
        #1;
        v = reg_rdata;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Reference model of every cell and of the emulated bus, checked each cycle.
    always @(posedge clock) begin
        if (sys_rst) begin
            exp_q <= 8'h00;
            exp_s <= 8'h00;
            exp_lvl <= BUS_IDLE_LEVEL;
            exp_cont <= 1'h0;
            exp_flt <= 1'h1;
        end else begin
            // The hidden bit of an inverted cell shows through again when its mode changes.
            for (int i = 0; i < 8; i++) begin
                next_q[i] = cell_next(sh_mode[3*i+:3], group_ctrl.group_control_line_one,
                    group_ctrl.group_control_line_two, load_data[i],
                    sh_run & (sh_clk[i] ? group_ctrl.line_four : group_ctrl.line_three),
                    sh_sync[i], exp_s[i] ^ inv_of(sh_mode[3*i+:3]));
                exp_q[i] <= next_q[i];
                exp_s[i] <= next_q[i] ^ inv_of(sh_mode[3*i+:3]);
            end
            exp_cont <= $countones(sh_drive) > 1;
            exp_flt <= sh_drive == 8'h00;
            exp_lvl <= ($countones(sh_drive) > 1) ? 1'h0 : (sh_drive == 8'h00) ? 1'h1 :
                |(sh_drive & exp_q);
        end
        #1;
        check_word("cell_q", {24'h00_0000, exp_q}, {24'h00_0000, cell_q});
        check_bit("bus_level", exp_lvl, bus_level);
        check_bit("bus_contention", exp_cont, bus_contention);
        check_bit("bus_floating", exp_flt, bus_floating);
    end

    // Random group lines and load data while the random phase runs.
    always @(posedge clock) begin
        if (lines_rand) begin
            seed_b = lfsr(seed_b);
            next_ctrl <= seed_b[3:0];
            next_data <= seed_b[15:8];
        end
    end

    // The whole run needs well under 10,000 cycles; this limit is five times that.
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] w;
        repeat (4) @(posedge clock);
        sys_rst <= 1'h0;
        bus_read(ADDR_STATUS, rd);
        check_word("status_reset", 32'h0005_0000, rd);
        bus_read(ADDR_MODE, rd);
        check_word("mode_reset", 32'h0000_0000, rd);
        w = 32'h0000_0000;
        foreach (codes[i]) w[3*i+:3] = codes[i];
        bus_write(ADDR_MODE, w);
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            next_ctrl <= {2'b00, k[1], k[0]};
            next_data <= {8{k[2]}} ^ 8'h5a;
            repeat (2) @(posedge clock);
        end
        $display("test cell_modes done");
        bus_write(ADDR_CTRL, 32'h0000_0001);
        bus_write(ADDR_MODE, 32'h0000_0000);
        bus_read(ADDR_MODE, rd);
        check_word("mode_frozen", {8'h00, w[23:0]}, rd);
        bus_write(ADDR_CTRL, 32'h0000_0000);
        bus_write(ADDR_MODE, 32'h0000_0024);
        bus_read(ADDR_MODE, rd);
        check_word("mode_illegal", {26'h000_0000, w[5:0]}, rd);
        bus_write(ADDR_MODE, w);
        foreach (drv[i]) begin
            bus_write(ADDR_DRIVE, {24'h00_0000, drv[i]});
            repeat (3) @(posedge clock);
        end
        $display("test bus_emulation done");
        lines_rand <= 1'h1;
        for (int n = 0; n < 600; n++) begin
            seed_a = lfsr(seed_a);
            w[15:0] = seed_a;
            seed_a = lfsr(seed_a);
            w[31:16] = seed_a;
            bus_write(addrs[w[2:0]], w);
            if (w[4] && addrs[w[2:0]] != ADDR_STATUS) begin
                bus_read(addrs[w[2:0]], rd);
                check_word("register", exp_reg(addrs[w[2:0]]), rd);
            end
        end
        lines_rand <= 1'h0;
        $display("test random done");
        report_and_stop();
    end
endmodule
